// file: src/smf_pkg.sv
// Package of constants shared by the motion supervision and feedback block.
package smf_pkg;
	// ----------------------------------------------------------------
	// Clock and timing
	// ----------------------------------------------------------------
	localparam int MCLK_HZ = 25000000;
	localparam int MAX_PULSE_PPS = 1600000;
	// Highest allowed output rate gives the least phase A period, rounded down.
	localparam int MIN_A_PERIOD_CYC = MCLK_HZ / MAX_PULSE_PPS;
	localparam int QUAD_STEPS_PER_CYCLE = 4;
	localparam int INDEX_WIDTH_STEPS = 2;

	// ----------------------------------------------------------------
	// Register byte offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_MAX_SPEED = 8'h04;
	localparam logic [7:0] OFS_DIV_COUNT = 8'h08;
	localparam logic [7:0] OFS_FWD_LIMIT = 8'h0c;
	localparam logic [7:0] OFS_REV_LIMIT = 8'h10;
	localparam logic [7:0] OFS_STATUS = 8'h14;

	// ----------------------------------------------------------------
	// Field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_SEL_LSB = 0;
	localparam int CTRL_CMD_CHECK_BIT = 4;
	localparam int ST_OVERSPEED = 0;
	localparam int ST_DIV_SETTING = 1;
	localparam int ST_DIV_OVERSPEED = 2;
	localparam int ST_ORIGIN = 3;
	localparam int ST_FWD_STOP = 4;
	localparam int ST_REV_STOP = 5;
	localparam int ST_CMD_CLAMP = 6;
	localparam int STICKY_BITS = 3;
	localparam logic [1:0] RST_SOFT_SEL = 2'h3;
	localparam logic [15:0] RST_MAX_SPEED = 16'h2710;
	localparam logic [30:0] RST_DIV_COUNT = 31'h000009c4;
	localparam logic [31:0] RST_FWD_LIMIT = 32'h3fffffff;
	localparam logic [31:0] RST_REV_LIMIT = 32'hc0000001;
	localparam logic [30:0] DIV_COUNT_MIN = 31'h00000010;
	localparam logic [30:0] DIV_COUNT_MAX = 31'h40000000;

	// ----------------------------------------------------------------
	// Soft limit select codes
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		SMF_SEL_BOTH_ON,
		SMF_SEL_FWD_OFF,
		SMF_SEL_REV_OFF,
		SMF_SEL_BOTH_OFF
	} smf_sel_t;
endpackage

// file: src/smf_quad.sv
// Quadrature phase generator stepping one gray state per request.
`timescale 1ns/1ps
module smf_quad (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic step,
	input wire logic dir_rev,
	output logic phase_a,
	output logic phase_b
);
	logic [1:0] cnt_r;
	logic [1:0] cnt_nxt;

	// Forward counts up so A leads B, reverse counts down so B leads A.
	assign cnt_nxt = dir_rev ? cnt_r - 2'h1 : cnt_r + 2'h1;

	// Gray sequence 00,10,11,01 keeps the two phases 90 degrees apart.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 2'h0;
			phase_a <= 1'b0;
			phase_b <= 1'b0;
		end else if (step) begin
			cnt_r <= cnt_nxt;
			phase_a <= cnt_nxt[1] ^ cnt_nxt[0];
			phase_b <= cnt_nxt[1];
		end
	end
endmodule

// file: src/smf_top.sv
// Motion supervision: overspeed, divided encoder output and software limits.
// Operation
// - Raise the overspeed alarm when measured speed exceeds the max speed setting (default 10000 rpm).
// - Output divided feedback as phases A and B held 90 degrees apart, made from the encoder counts.
// - Emit exactly the divided pulse count of A/B pulses per revolution (16 to 1073741824, default 2500).
// - Emit one index pulse for every full motor revolution.
// - Make the index pulse as wide as one phase A pulse.
// - Raise the divider setting alarm when the count cannot be met for the encoder or breaks the setting step.
// - Raise the divided output overspeed alarm when the output would exceed about 1.6 Mpps.
// - With a soft limit enabled, force a stop once position passes it, without overtravel inputs.
// - Soft limits become active on zero return done, position set with reference flag 1, or sensor on with an absolute encoder.
// - Before the origin is known, take no soft limit action at all.
// - Select code 0 enables both limits, 1 drops forward, 2 drops reverse, 3 drops both; default 3.
// - An optional command check, off by default, examines positioning and interpolation targets.
// - With the check on, a target beyond a limit is replaced by a decelerated stop at that limit.
`timescale 1ns/1ps
module smf_top
	import smf_pkg::*;
#(
	parameter int ENC_RES = 1048576,
	parameter int DIV_STEP = 4
) (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	input wire logic enc_step,
	input wire logic enc_dir_rev,
	input wire logic [16:0] motor_speed_rpm,
	input wire logic [31:0] machine_position,
	input wire logic abs_encoder,
	input wire logic zero_return_cmd,
	input wire logic pos_set_cmd,
	input wire logic reference_valid_flag,
	input wire logic sensor_on_cmd,
	input wire logic positioning_cmd,
	input wire logic interpolation_cmd,
	input wire logic [31:0] cmd_target,
	output logic divided_phase_a_out,
	output logic divided_phase_b_out,
	output logic index_pulse_out,
	output logic overspeed_alarm,
	output logic div_setting_alarm,
	output logic div_overspeed_alarm,
	output logic soft_stop_fwd,
	output logic soft_stop_rev,
	output logic cmd_target_valid,
	output logic [31:0] cmd_target_out,
	output logic cmd_decel_stop
);
	import smf_pkg::*;

	// ----------------------------------------------------------------
	// Register bus
	// ----------------------------------------------------------------
	logic [1:0] sel_r;
	logic cmd_check_r;
	logic [15:0] max_speed_r;
	logic [30:0] div_count_r;
	logic [31:0] fwd_limit_r;
	logic [31:0] rev_limit_r;
	logic [STICKY_BITS-1:0] sticky_r;
	logic origin_r;
	logic wr_pend_r;
	logic [7:0] wr_addr_r;

	wire addr_take = hsel & htrans[1] & hready;
	wire [7:0] ofs = haddr[7:0];
	wire wr_ctrl = wr_pend_r & (wr_addr_r == OFS_CTRL);
	wire wr_speed = wr_pend_r & (wr_addr_r == OFS_MAX_SPEED);
	wire wr_div = wr_pend_r & (wr_addr_r == OFS_DIV_COUNT);
	wire wr_fwd = wr_pend_r & (wr_addr_r == OFS_FWD_LIMIT);
	wire wr_rev = wr_pend_r & (wr_addr_r == OFS_REV_LIMIT);
	wire wr_status = wr_pend_r & (wr_addr_r == OFS_STATUS);
	wire [31:0] status_word = {25'h0000000, cmd_decel_stop, soft_stop_rev, soft_stop_fwd, origin_r, sticky_r};
	logic [31:0] rd_word;

	// Read selection; unmapped offsets read as zero and writes to them are dropped.
	always_comb begin
		if (ofs == OFS_CTRL) begin
			rd_word = {27'h0000000, cmd_check_r, 2'h0, sel_r};
		end else if (ofs == OFS_MAX_SPEED) begin
			rd_word = {16'h0000, max_speed_r};
		end else if (ofs == OFS_DIV_COUNT) begin
			rd_word = {1'b0, div_count_r};
		end else if (ofs == OFS_FWD_LIMIT) begin
			rd_word = fwd_limit_r;
		end else if (ofs == OFS_REV_LIMIT) begin
			rd_word = rev_limit_r;
		end else if (ofs == OFS_STATUS) begin
			rd_word = status_word;
		end else begin
			rd_word = 32'h00000000;
		end
	end

	// Address phase is latched; zero wait states, response always OKAY.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata <= 32'h00000000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_r <= addr_take & hwrite;
			wr_addr_r <= ofs;
			if (addr_take & ~hwrite) begin
				hrdata <= rd_word;
			end
		end
	end

	// Settings take effect at once; the data phase write lands here.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sel_r <= RST_SOFT_SEL;
			cmd_check_r <= 1'b0;
			max_speed_r <= RST_MAX_SPEED;
			div_count_r <= RST_DIV_COUNT;
			fwd_limit_r <= RST_FWD_LIMIT;
			rev_limit_r <= RST_REV_LIMIT;
		end else begin
			if (wr_ctrl) begin
				sel_r <= hwdata[CTRL_SEL_LSB+:2];
				cmd_check_r <= hwdata[CTRL_CMD_CHECK_BIT];
			end
			if (wr_speed) begin
				max_speed_r <= hwdata[15:0];
			end
			if (wr_div) begin
				div_count_r <= hwdata[30:0];
			end
			if (wr_fwd) begin
				fwd_limit_r <= hwdata;
			end
			if (wr_rev) begin
				rev_limit_r <= hwdata;
			end
		end
	end

	// ----------------------------------------------------------------
	// Divided pulse generation
	// ----------------------------------------------------------------
	localparam logic [33:0] RES34 = 34'(ENC_RES);
	localparam logic [30:0] STEP31 = 31'(DIV_STEP);
	logic [33:0] acc_r;
	logic [33:0] acc_nxt;
	logic [31:0] rev_pos_r;
	logic quad_step;
	logic [1:0] idx_steps_r;
	logic prev_a_r;
	logic [7:0] a_gap_r;

	wire [33:0] inc = {1'b0, div_count_r, 2'b00};
	wire [33:0] acc_up = acc_r + inc;
	wire div_bad = (div_count_r < DIV_COUNT_MIN) | (div_count_r > DIV_COUNT_MAX) | (inc > RES34)
		| ((div_count_r % STEP31) != 31'h00000000);
	wire at_top = (rev_pos_r == 32'(ENC_RES - 1));
	wire at_zero = (rev_pos_r == 32'h00000000);
	wire rev_wrap = enc_step & (enc_dir_rev ? at_zero : at_top);
	wire a_rise = divided_phase_a_out & ~prev_a_r;
	wire [7:0] min_gap = 8'(MIN_A_PERIOD_CYC);

	// Four quadrature states make one A pulse, so the accumulator adds 4N per count.
	always_comb begin
		acc_nxt = acc_r;
		quad_step = 1'b0;
		if (enc_step & ~div_bad) begin
			if (!enc_dir_rev) begin
				if (acc_up >= RES34) begin
					acc_nxt = acc_up - RES34;
					quad_step = 1'b1;
				end else begin
					acc_nxt = acc_up;
				end
			end else if (acc_r < inc) begin
				acc_nxt = acc_r + RES34 - inc;
				quad_step = 1'b1;
			end else begin
				acc_nxt = acc_r - inc;
			end
		end
	end

	// Position within one revolution marks where the index pulse belongs.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			acc_r <= 34'h000000000;
			rev_pos_r <= 32'h00000000;
		end else begin
			acc_r <= acc_nxt;
			if (enc_step) begin
				if (enc_dir_rev) begin
					rev_pos_r <= at_zero ? 32'(ENC_RES - 1) : rev_pos_r - 32'h00000001;
				end else begin
					rev_pos_r <= at_top ? 32'h00000000 : rev_pos_r + 32'h00000001;
				end
			end
		end
	end

	smf_quad u_quad (
		.mclk(mclk),
		.rstn(rstn),
		.step(quad_step),
		.dir_rev(enc_dir_rev),
		.phase_a(divided_phase_a_out),
		.phase_b(divided_phase_b_out)
	);

	// Index stays high for two quadrature steps, the width of an A high time.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			index_pulse_out <= 1'b0;
			idx_steps_r <= 2'h0;
		end else if (rev_wrap & ~div_bad) begin
			index_pulse_out <= 1'b1;
			idx_steps_r <= 2'h0;
		end else if (index_pulse_out & quad_step) begin
			idx_steps_r <= idx_steps_r + 2'h1;
			if (idx_steps_r == 2'(INDEX_WIDTH_STEPS - 1)) begin
				index_pulse_out <= 1'b0;
			end
		end
	end

	// A rising edges closer than the least period mean the rate passed its cap.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			prev_a_r <= 1'b0;
			a_gap_r <= 8'hff;
		end else begin
			prev_a_r <= divided_phase_a_out;
			if (a_rise) begin
				a_gap_r <= 8'h01;
			end else if (a_gap_r != 8'hff) begin
				a_gap_r <= a_gap_r + 8'h01;
			end
		end
	end

	// ----------------------------------------------------------------
	// Alarms, sticky until written one; a new event beats the clear
	// ----------------------------------------------------------------
	wire speed_hi = motor_speed_rpm[16] ? ({1'b0, (~motor_speed_rpm[15:0]) + 16'h0001} > {1'b0, max_speed_r})
		: (motor_speed_rpm[15:0] > max_speed_r);
	wire [STICKY_BITS-1:0] ev = {a_rise & (a_gap_r < min_gap), div_bad, speed_hi};
	wire [STICKY_BITS-1:0] clr = wr_status ? hwdata[STICKY_BITS-1:0] : {STICKY_BITS{1'b0}};

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sticky_r <= {STICKY_BITS{1'b0}};
			overspeed_alarm <= 1'b0;
			div_setting_alarm <= 1'b0;
			div_overspeed_alarm <= 1'b0;
		end else begin
			sticky_r <= (sticky_r & ~clr) | ev;
			overspeed_alarm <= (sticky_r[ST_OVERSPEED] & ~clr[ST_OVERSPEED]) | ev[ST_OVERSPEED];
			div_setting_alarm <= (sticky_r[ST_DIV_SETTING] & ~clr[ST_DIV_SETTING]) | ev[ST_DIV_SETTING];
			div_overspeed_alarm <= (sticky_r[ST_DIV_OVERSPEED] & ~clr[ST_DIV_OVERSPEED])
				| ev[ST_DIV_OVERSPEED];
		end
	end

	// ----------------------------------------------------------------
	// Software limits
	// ----------------------------------------------------------------
	wire fwd_en = origin_r & ((sel_r == SMF_SEL_BOTH_ON) | (sel_r == SMF_SEL_REV_OFF));
	wire rev_en = origin_r & ((sel_r == SMF_SEL_BOTH_ON) | (sel_r == SMF_SEL_FWD_OFF));
	wire cmd_in = positioning_cmd | interpolation_cmd;
	wire tgt_over = fwd_en & ($signed(cmd_target) > $signed(fwd_limit_r));
	wire tgt_under = rev_en & ($signed(cmd_target) < $signed(rev_limit_r));
	wire tgt_clamp = cmd_check_r & (tgt_over | tgt_under);

	// The origin is known after homing, a referenced position set, or absolute sensor on.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			origin_r <= 1'b0;
		end else if (zero_return_cmd | (pos_set_cmd & reference_valid_flag) | (abs_encoder & sensor_on_cmd)) begin
			origin_r <= 1'b1;
		end else if (pos_set_cmd) begin
			origin_r <= 1'b0;
		end
	end

	// Stops follow position directly; overtravel inputs are not consulted.
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			soft_stop_fwd <= 1'b0;
			soft_stop_rev <= 1'b0;
			cmd_target_valid <= 1'b0;
			cmd_target_out <= 32'h00000000;
			cmd_decel_stop <= 1'b0;
		end else begin
			soft_stop_fwd <= fwd_en & ($signed(machine_position) > $signed(fwd_limit_r));
			soft_stop_rev <= rev_en & ($signed(machine_position) < $signed(rev_limit_r));
			cmd_target_valid <= cmd_in;
			if (cmd_in) begin
				cmd_decel_stop <= tgt_clamp;
				if (tgt_clamp & tgt_over) begin
					cmd_target_out <= fwd_limit_r;
				end else if (tgt_clamp) begin
					cmd_target_out <= rev_limit_r;
				end else begin
					cmd_target_out <= cmd_target;
				end
			end
		end
	end
endmodule

// file: testbench/smf_top_asserts.sv
// Concurrent checks on the ports of the motion supervision block.
`timescale 1ns/1ps
module smf_top_asserts (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic enc_step,
	input wire logic enc_dir_rev,
	input wire logic positioning_cmd,
	input wire logic interpolation_cmd,
	input wire logic divided_phase_a_out,
	input wire logic divided_phase_b_out,
	input wire logic index_pulse_out,
	input wire logic soft_stop_fwd,
	input wire logic soft_stop_rev,
	input wire logic cmd_target_valid,
	input wire logic [31:0] cmd_target_out,
	input wire logic cmd_decel_stop
);
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rstn);
	// Either command kind counts as a request.
	wire cmd_in = positioning_cmd | interpolation_cmd;

	// ----------------------------------------------------------------
	// Command path
	// ----------------------------------------------------------------
	a_cmd_answer: assert property (cmd_in |=> cmd_target_valid)
		else $error("command not answered next cycle");
	a_cmd_no_spur: assert property (cmd_target_valid |-> $past(cmd_in))
		else $error("command result without a command");
	a_cmd_hold: assert property (!cmd_in |=> $stable(cmd_target_out) && $stable(cmd_decel_stop))
		else $error("command result moved without a command");

	// ----------------------------------------------------------------
	// Quadrature output
	// ----------------------------------------------------------------
	a_quad_gray: assert property (!($changed(divided_phase_a_out) && $changed(divided_phase_b_out)))
		else $error("both phases changed together");
	a_quad_cause: assert property (($changed(divided_phase_a_out) || $changed(divided_phase_b_out))
		|-> $past(enc_step))
		else $error("phase moved without an encoder count");
	a_quad_dir: assert property ($rose(divided_phase_a_out) |-> divided_phase_b_out == $past(enc_dir_rev))
		else $error("phase lead does not match direction");
	a_index_cause: assert property ($rose(index_pulse_out) |-> $past(enc_step))
		else $error("index rose without an encoder count");
	// The limits are ordered, so both stops together means a wrong compare.
	a_stop_excl: assert property (!(soft_stop_fwd && soft_stop_rev))
		else $error("both soft stops active");

	cover property ($rose(index_pulse_out));
	cover property (cmd_target_valid && cmd_decel_stop);
	cover property ($rose(soft_stop_rev));
endmodule

bind smf_top smf_top_asserts smf_top_asserts_i (.mclk(mclk), .rstn(rstn), .enc_step(enc_step),
	.enc_dir_rev(enc_dir_rev), .positioning_cmd(positioning_cmd), .interpolation_cmd(interpolation_cmd),
	.divided_phase_a_out(divided_phase_a_out), .divided_phase_b_out(divided_phase_b_out),
	.index_pulse_out(index_pulse_out), .soft_stop_fwd(soft_stop_fwd), .soft_stop_rev(soft_stop_rev),
	.cmd_target_valid(cmd_target_valid), .cmd_target_out(cmd_target_out), .cmd_decel_stop(cmd_decel_stop));

// file: testbench/smf_host.sv
// Host-side model that decodes the divided quadrature and index outputs.
`timescale 1ns/1ps
module smf_host (
	input wire logic mclk,
	input wire logic rstn,
	input wire logic phase_a,
	input wire logic phase_b,
	input wire logic index_in,
	output int pos,
	output int a_rises,
	output int idx_count,
	output int a_hi,
	output int idx_hi,
	output int bad_steps
);
	logic [1:0] g_r;
	logic a_r, i_r;
	int a_run, i_run;
	// Gray position 0..3 for states 00, 10, 11, 01 of A and B.
	wire [1:0] g = {phase_b, phase_a ^ phase_b};
	wire [1:0] d = g - g_r;
	// A jump of two gray states means an edge was lost, which a real counter cannot recover.
	always @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			{pos, a_rises, idx_count, a_hi, idx_hi, bad_steps, a_run, i_run} <= '0;
			{g_r, a_r, i_r} <= '0;
		end else begin
			if (d == 2'h1) pos <= pos + 1;
			else if (d == 2'h3) pos <= pos - 1;
			else if (d == 2'h2) bad_steps <= bad_steps + 1;
			if (phase_a && !a_r) a_rises <= a_rises + 1;
			if (index_in && !i_r) idx_count <= idx_count + 1;
			a_run <= phase_a ? a_run + 1 : 0;
			i_run <= index_in ? i_run + 1 : 0;
			if (a_r && !phase_a) a_hi <= a_run;
			if (i_r && !index_in) idx_hi <= i_run;
			g_r <= g;
			a_r <= phase_a;
			i_r <= index_in;
		end
	end
endmodule

// file: testbench/smf_top_bench.sv
// Self-checking bench for the motion supervision and feedback block.
`timescale 1ns/1ps
module smf_top_bench;
	import smf_pkg::*;
	localparam int RES = 256;
	logic mclk, rstn, hsel, hwrite, enc_step, enc_dir_rev, abs_encoder, reference_valid_flag;
	logic [31:0] haddr, hwdata, hrdata, machine_position, cmd_target, cmd_target_out, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	logic [16:0] motor_speed_rpm;
	logic [4:0] cp;
	logic hreadyout, hresp, pa, pb, pc, osa, dsa, doa, sf, sr, cv, cds;
	logic [32:0] exp_q[$];
	int n_mismatch, compares, seed, pos, a_rises, idx_count, a_hi, idx_hi, bad_steps;
	int bad[5] = '{2501, 12, 18, 128, 32'h40000004};

	smf_top #(.ENC_RES(RES)) smf_top_i (.mclk(mclk), .rstn(rstn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .enc_step(enc_step),
		.enc_dir_rev(enc_dir_rev), .motor_speed_rpm(motor_speed_rpm), .machine_position(machine_position),
		.abs_encoder(abs_encoder), .zero_return_cmd(cp[0]), .pos_set_cmd(cp[1]),
		.reference_valid_flag(reference_valid_flag), .sensor_on_cmd(cp[2]), .positioning_cmd(cp[3]),
		.interpolation_cmd(cp[4]), .cmd_target(cmd_target), .divided_phase_a_out(pa),
		.divided_phase_b_out(pb), .index_pulse_out(pc), .overspeed_alarm(osa), .div_setting_alarm(dsa),
		.div_overspeed_alarm(doa), .soft_stop_fwd(sf), .soft_stop_rev(sr), .cmd_target_valid(cv),
		.cmd_target_out(cmd_target_out), .cmd_decel_stop(cds));
	smf_host smf_host_i (.mclk(mclk), .rstn(rstn), .phase_a(pa), .phase_b(pb), .index_in(pc), .pos(pos),
		.a_rises(a_rises), .idx_count(idx_count), .a_hi(a_hi), .idx_hi(idx_hi), .bad_steps(bad_steps));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task automatic check(input logic [32:0] seen, input logic [32:0] want, input string what);
		compares++;
		if (seen !== want) begin
			n_mismatch++;
			$display("[ERR] %0t %s: saw %h want %h", $time, what, seen, want);
		end
	endtask
	// One single transfer; no cycle count is assumed, the watchdog ends a hang.
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge mclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		do @(posedge mclk); while (hreadyout !== 1'b1);
		hsel <= 1'b0;
		htrans <= 2'h0;
		hwdata <= d;
		do @(posedge mclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic rdchk(input logic [7:0] a, input logic [31:0] want);
		ahb(1'b0, a, 32'h0);
		check(rd, want, "register");
	endtask
	// Ends on a rising edge so the next input change lands on the edge; outputs read here are
	// the settled values from the edge before, since the design updates by non-blocking assignment.
	task automatic settle;
		repeat (3) @(posedge mclk);
	endtask
	task automatic pulse(input int k);
		@(posedge mclk);
		cp <= 5'h1 << k;
		@(posedge mclk);
		cp <= 5'h0;
	endtask
	task automatic cmd(input int k, input logic [31:0] t, input logic [32:0] want);
		exp_q.push_back(want);
		cmd_target <= t;
		pulse(k);
	endtask
	// Steps every other cycle, well inside the one-count-per-cycle limit.
	task automatic spin(input int n, input logic rev);
		repeat (n) begin
			@(posedge mclk);
			enc_step <= 1'b1;
			enc_dir_rev <= rev;
			@(posedge mclk);
			enc_step <= 1'b0;
		end
	endtask
	task automatic complete_run;
		$display("Mismatches %0d of %0d comparisons", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Processes
	// ----------------------------------------------------------------
	initial begin
		mclk = 1'b0;
		forever #20 mclk = ~mclk;
	end
	// Command results are matched in order against the notes of the driver.
	always @(posedge mclk) begin
		if (cv === 1'b1) check({cds, cmd_target_out}, exp_q.pop_front(), "command");
	end
	initial begin
		#(40 * 20000);
		n_mismatch++;
		complete_run;
	end
	initial begin
		{rstn, hsel, hwrite, enc_step, enc_dir_rev, reference_valid_flag, cp} = '0;
		{haddr, hwdata, machine_position, cmd_target, htrans, motor_speed_rpm} = '0;
		hsize = 3'h2;
		abs_encoder = 1'b1;
		seed = 72;
		repeat (2) @(posedge mclk);
		rstn <= 1'b1;
		rdchk(OFS_CTRL, 32'h3);
		rdchk(OFS_MAX_SPEED, 32'h2710);
		rdchk(OFS_DIV_COUNT, 32'h9c4);
		rdchk(OFS_FWD_LIMIT, 32'h3fffffff);
		rdchk(OFS_REV_LIMIT, 32'hc0000001);
		rdchk(8'h18, 32'h0);
		// Divided output: three turns forward, then just over one back.
		// The forward run stops on the index, which stays high, so the reverse turn needs one more count.
		ahb(1'b1, OFS_DIV_COUNT, 32'h10);
		ahb(1'b1, OFS_STATUS, 32'h7);
		settle; check(dsa, 1'b0, "divider alarm");
		spin(3 * RES, 1'b0);
		settle; check(a_rises, 48, "A pulses");
		check(pos, 192, "quad steps");
		check(idx_count, 3, "index count");
		check(idx_hi, a_hi, "index width");
		check(doa, 1'b0, "rate alarm");
		spin(RES + 1, 1'b1);
		settle; check(pos, 127, "reverse steps");
		check(idx_count, 4, "reverse index");
		check(bad_steps, 0, "gray jumps");
		ahb(1'b1, OFS_DIV_COUNT, 32'h40);
		spin(RES, 1'b0);
		settle; check(doa, 1'b1, "rate alarm");
		foreach (bad[i]) begin
			ahb(1'b1, OFS_DIV_COUNT, 32'h10);
			ahb(1'b1, OFS_STATUS, 32'h7);
			ahb(1'b1, OFS_DIV_COUNT, bad[i]);
			settle; check(dsa, 1'b1, "divider alarm");
		end
		ahb(1'b1, OFS_DIV_COUNT, 32'h10);
		// Speed supervision with random legal speeds first.
		ahb(1'b1, OFS_MAX_SPEED, 32'h64);
		repeat (8) begin
			motor_speed_rpm <= 17'($random(seed) % 101);
			settle; check(osa, 1'b0, "overspeed");
		end
		motor_speed_rpm <= 17'h1ff9b;
		settle; check(osa, 1'b1, "overspeed");
		motor_speed_rpm <= 17'h0;
		ahb(1'b1, OFS_STATUS, 32'h1);
		settle; check(osa, 1'b0, "overspeed clear");
		// Soft limits at plus and minus 100.
		ahb(1'b1, OFS_FWD_LIMIT, 32'h64);
		ahb(1'b1, OFS_REV_LIMIT, 32'hffffff9c);
		ahb(1'b1, OFS_CTRL, 32'h0);
		machine_position <= 32'hc8;
		settle; check(sf, 1'b0, "before origin");
		for (int s = 0; s < 4; s++) begin
			pulse(0);
			ahb(1'b1, OFS_CTRL, s);
			machine_position <= 32'hc8;
			settle; check(sf, s == 0 || s == 2, "forward stop");
			machine_position <= 32'hffffff38;
			settle; check(sr, s < 2, "reverse stop");
		end
		ahb(1'b1, OFS_CTRL, 32'h0);
		machine_position <= 32'hc8;
		for (int k = 0; k < 3; k++) begin
			reference_valid_flag <= 1'b0;
			pulse(1);
			settle; check(sf, 1'b0, "origin lost");
			reference_valid_flag <= 1'b1;
			pulse(k);
			settle; check(sf, 1'b1, "origin set");
		end
		// Sensor on fixes no origin when the encoder is incremental.
		reference_valid_flag <= 1'b0;
		pulse(1);
		abs_encoder <= 1'b0;
		pulse(2);
		settle;
		check(sf, 1'b0, "sensor on, incremental");
		abs_encoder <= 1'b1;
		pulse(0);
		machine_position <= 32'h64;
		settle; check(sf, 1'b0, "on the limit");
		// Command targets with the check off, then on.
		cmd(3, 32'h1f4, {1'b0, 32'h1f4});
		ahb(1'b1, OFS_CTRL, 32'h10);
		cmd(3, 32'h1f4, {1'b1, 32'h64});
		cmd(4, 32'hfffffe0c, {1'b1, 32'hffffff9c});
		cmd(4, 32'h32, {1'b0, 32'h32});
		settle; check(exp_q.size(), 0, "results left");
		complete_run;
	end
endmodule
